// File: logic/cfbs_consts.vh
`ifndef CFBS_CONSTS_VH
`define CFBS_CONSTS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define CFBS_OFF_PTR      8'h00
`define CFBS_OFF_SEL      8'h04
`define CFBS_OFF_WORD6    8'h08
`define CFBS_OFF_WORD7    8'h0C
`define CFBS_OFF_TXMASK   8'h10
`define CFBS_OFF_STATUS   8'h14

// ****************************************
// Register select codes
// ****************************************
`define CFBS_SEL_PTR      3'h0
`define CFBS_SEL_BSEL     3'h1
`define CFBS_SEL_WORD6    3'h2
`define CFBS_SEL_WORD7    3'h3
`define CFBS_SEL_TXMASK   3'h4
`define CFBS_SEL_STATUS   3'h5
`define CFBS_SEL_NONE     3'h7

// ****************************************
// Pointer fields and destinations
// ****************************************
`define CFBS_F11_LSB      12
`define CFBS_F10_LSB      8
`define CFBS_F9_LSB       4
`define CFBS_F8_LSB       0
`define CFBS_PTR_RESET    16'h0000
`define CFBS_DEST_FIFO    4'hF
`define CFBS_FILT_11      4'hB
`define CFBS_FILT_10      4'hA
`define CFBS_FILT_9       4'h9
`define CFBS_FILT_8       4'h8

// ****************************************
// Buffer word fields
// ****************************************
`define CFBS_HIT_LSB      8
`define CFBS_HIT_MSB      12
`define CFBS_NUM_BUF      15
`define CFBS_TXMASK_RESET 15'h0000

// ****************************************
// Staging word layout
// ****************************************
`define CFBS_STG_W        25
`define CFBS_STG_DEST_LSB 21
`define CFBS_STG_HIT_LSB  16
`define CFBS_STG_DEPTH    8
`define CFBS_STG_AW       3

// ****************************************
// AXI responses
// ****************************************
`define CFBS_RESP_OKAY    2'h0
`define CFBS_RESP_SLVERR  2'h2

`endif

// File: logic/cfbs_fifo.v
`timescale 1ns/100ps
`default_nettype none

module cfbs_fifo #(
    parameter WIDTH = 25,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rstn,
    // Fill side
    input  wire             in_valid,
    output reg              in_ready,
    input  wire [WIDTH-1:0] in_data,
    // Drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_q;
    reg [AW-1:0]    rd_ptr_q;
    reg [AW:0]      count_q;
    reg [AW:0]      count_d;
    wire            push;
    wire            pop;

    assign out_valid = (count_q != {(AW+1){1'b0}});
    assign out_data  = mem_q[rd_ptr_q];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @*
    begin
        count_d = count_q;
        if (push & ~pop)
            count_d = count_q + 1'b1;
        else if (pop & ~push)
            count_d = count_q - 1'b1;
    end

    always @(posedge clk)
    begin
        if (push)
            mem_q[wr_ptr_q] <= in_data;
    end

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_ptr_q <= {AW{1'b0}};
            rd_ptr_q <= {AW{1'b0}};
            count_q  <= {(AW+1){1'b0}};
            in_ready <= 1'b1;
        end
        else
        begin
            if (push)
                wr_ptr_q <= (wr_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_q + 1'b1;
            if (pop)
                rd_ptr_q <= (rd_ptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_q + 1'b1;
            count_q  <= count_d;
            in_ready <= (count_d != DEPTH[AW:0]);
        end
    end

endmodule // cfbs_fifo

`default_nettype wire

// File: logic/cfbs_top.v
// Functional notes
// - Filter eleven frames go where bits 15-12 point; 1111 means FIFO, else buffer.
// - Filters ten, nine, eight use bits 11-8, 7-4, 3-0, same encoding.
// - Byte seven sits in bits 15:8 of word six, undefined after reset.
// - Byte six sits in bits 7:0 of word six, software read and write.
// - Received frame stores accepting filter number in hit code bits 12-8, word seven.
// - Hit code written only for receive buffers, never for transmit buffers.
// - Word seven bits 15-13 and 7-0 always read as zero.
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "cfbs_consts.vh"

module cfbs_top (
    // Clock and reset
    input  wire        clk,
    input  wire        rstn,
    // AXI4-Lite write address
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // AXI4-Lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // AXI4-Lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read address
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // AXI4-Lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Accepted frame input
    input  wire        frame_valid,
    output wire        frame_ready,
    input  wire [3:0]  frame_filter,
    input  wire [7:0]  frame_byte6,
    input  wire [7:0]  frame_byte7,
    // Receive FIFO output
    output reg         rxq_valid,
    input  wire        rxq_ready,
    output reg  [4:0]  rxq_hit,
    output reg  [15:0] rxq_bytes
);

    // ****************************************
    // Declarations
    // ****************************************
    reg  [15:0]              ptr_q;
    reg  [3:0]               bsel_q;
    reg  [`CFBS_NUM_BUF-1:0] txmask_q;
    reg  [15:0]              word6_q [0:`CFBS_NUM_BUF-1];
    reg  [4:0]               hit_q   [0:`CFBS_NUM_BUF-1];
    reg                      aw_got_q;
    reg                      w_got_q;
    reg  [7:0]               awaddr_q;
    reg  [31:0]              wdata_q;
    reg  [3:0]               wstrb_q;
    wire                     do_wr;
    wire [2:0]               wr_sel;
    wire [2:0]               rd_sel;
    wire                     bsel_ok;
    reg  [31:0]              rd_word;
    wire [3:0]               acc_dest;
    wire [`CFBS_STG_W-1:0]   stg_in;
    wire                     stg_valid;
    wire                     stg_ready;
    wire [`CFBS_STG_W-1:0]   stg_out;
    wire [3:0]               stg_dest;
    wire [4:0]               stg_hit;
    wire [15:0]              stg_bytes;
    wire                     drain_ok;
    wire                     to_fifo;
    reg                      frame_ready_q;

    // ****************************************
    // Helper functions
    // ****************************************
    function [2:0] cfbs_decode;
        input [7:0] addr;
        begin
            case ({addr[7:2], 2'b00})
                `CFBS_OFF_PTR:    cfbs_decode = `CFBS_SEL_PTR;
                `CFBS_OFF_SEL:    cfbs_decode = `CFBS_SEL_BSEL;
                `CFBS_OFF_WORD6:  cfbs_decode = `CFBS_SEL_WORD6;
                `CFBS_OFF_WORD7:  cfbs_decode = `CFBS_SEL_WORD7;
                `CFBS_OFF_TXMASK: cfbs_decode = `CFBS_SEL_TXMASK;
                `CFBS_OFF_STATUS: cfbs_decode = `CFBS_SEL_STATUS;
                default:          cfbs_decode = `CFBS_SEL_NONE;
            endcase
        end
    endfunction

    // Destination for a filter from the pointer fields
    function [3:0] cfbs_dest;
        input [3:0]  filt;
        input [15:0] ptr;
        begin
            case (filt)
                `CFBS_FILT_11: cfbs_dest = ptr[`CFBS_F11_LSB +: 4];
                `CFBS_FILT_10: cfbs_dest = ptr[`CFBS_F10_LSB +: 4];
                `CFBS_FILT_9:  cfbs_dest = ptr[`CFBS_F9_LSB +: 4];
                `CFBS_FILT_8:  cfbs_dest = ptr[`CFBS_F8_LSB +: 4];
                default:       cfbs_dest = `CFBS_DEST_FIFO;
            endcase
        end
    endfunction

    // ****************************************
    // Frame staging
    // ****************************************
    // Destination fixed when the frame is accepted
    assign acc_dest    = cfbs_dest(frame_filter, ptr_q);
    assign stg_in      = {acc_dest, 1'b0, frame_filter, frame_byte7, frame_byte6};
    assign frame_ready = stg_ready;

    cfbs_fifo #(
        .WIDTH (`CFBS_STG_W),
        .DEPTH (`CFBS_STG_DEPTH),
        .AW    (`CFBS_STG_AW)
    ) u_stage (
        .clk       (clk),
        .rstn      (rstn),
        .in_valid  (frame_valid),
        .in_ready  (stg_ready),
        .in_data   (stg_in),
        .out_valid (stg_valid),
        .out_ready (drain_ok),
        .out_data  (stg_out)
    );

    assign stg_dest  = stg_out[`CFBS_STG_DEST_LSB +: 4];
    assign stg_hit   = stg_out[`CFBS_STG_HIT_LSB +: 5];
    assign stg_bytes = stg_out[15:0];
    assign to_fifo   = (stg_dest == `CFBS_DEST_FIFO);

    // Register writes take the buffers first
    assign drain_ok = stg_valid & ~do_wr & (~to_fifo | ~rxq_valid | rxq_ready);

    // ****************************************
    // Buffer storage
    // ****************************************
    assign wr_sel  = cfbs_decode(awaddr_q);
    assign bsel_ok = (bsel_q != `CFBS_DEST_FIFO);

    always @(posedge clk)
    begin
        if (drain_ok & ~to_fifo)
        begin
            word6_q[stg_dest] <= stg_bytes;
            if (~txmask_q[stg_dest])
                hit_q[stg_dest] <= stg_hit;
        end
        else if (do_wr & bsel_ok)
        begin
            if (wr_sel == `CFBS_SEL_WORD6)
            begin
                if (wstrb_q[0])
                    word6_q[bsel_q][7:0] <= wdata_q[7:0];
                if (wstrb_q[1])
                    word6_q[bsel_q][15:8] <= wdata_q[15:8];
            end
            if ((wr_sel == `CFBS_SEL_WORD7) & wstrb_q[1])
                hit_q[bsel_q] <= wdata_q[`CFBS_HIT_MSB:`CFBS_HIT_LSB];
        end
    end

    // ****************************************
    // Receive FIFO output
    // ****************************************
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rxq_valid <= 1'b0;
            rxq_hit   <= 5'h00;
            rxq_bytes <= 16'h0000;
        end
        else
        begin
            if (drain_ok & to_fifo)
            begin
                rxq_valid <= 1'b1;
                rxq_hit   <= stg_hit;
                rxq_bytes <= stg_bytes;
            end
            else if (rxq_ready)
                rxq_valid <= 1'b0;
        end
    end

    // ****************************************
    // AXI4-Lite write path
    // ****************************************
    assign do_wr = aw_got_q & w_got_q & ~s_axi_bvalid;

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `CFBS_RESP_OKAY;
            aw_got_q      <= 1'b0;
            w_got_q       <= 1'b0;
            awaddr_q      <= 8'h00;
            wdata_q       <= 32'h00000000;
            wstrb_q       <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid & s_axi_awready)
            begin
                awaddr_q      <= s_axi_awaddr;
                aw_got_q      <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid & s_axi_wready)
            begin
                wdata_q      <= s_axi_wdata;
                wstrb_q      <= s_axi_wstrb;
                w_got_q      <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_wr)
            begin
                aw_got_q     <= 1'b0;
                w_got_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_sel == `CFBS_SEL_NONE) ? `CFBS_RESP_SLVERR
                                                           : `CFBS_RESP_OKAY;
            end
            if (s_axi_bvalid & s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ****************************************
    // Control registers
    // ****************************************
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ptr_q    <= `CFBS_PTR_RESET;
            bsel_q   <= 4'h0;
            txmask_q <= `CFBS_TXMASK_RESET;
        end
        else if (do_wr)
        begin
            case (wr_sel)
                `CFBS_SEL_PTR:
                begin
                    // New pointer only steers frames accepted later
                    if (wstrb_q[0])
                        ptr_q[7:0] <= wdata_q[7:0];
                    if (wstrb_q[1])
                        ptr_q[15:8] <= wdata_q[15:8];
                end
                `CFBS_SEL_BSEL:
                begin
                    if (wstrb_q[0])
                        bsel_q <= wdata_q[3:0];
                end
                `CFBS_SEL_TXMASK:
                begin
                    if (wstrb_q[0])
                        txmask_q[7:0] <= wdata_q[7:0];
                    if (wstrb_q[1])
                        txmask_q[14:8] <= wdata_q[14:8];
                end
                default:
                begin
                    ptr_q <= ptr_q;
                end
            endcase
        end
    end

    // ****************************************
    // AXI4-Lite read path
    // ****************************************
    assign rd_sel = cfbs_decode(s_axi_araddr);

    always @*
    begin
        rd_word = 32'h00000000;
        case (rd_sel)
            `CFBS_SEL_PTR:
                rd_word[15:0] = ptr_q;
            `CFBS_SEL_BSEL:
                rd_word[3:0] = bsel_q;
            `CFBS_SEL_WORD6:
                if (bsel_ok)
                    rd_word[15:0] = word6_q[bsel_q];
            `CFBS_SEL_WORD7:
                if (bsel_ok)
                    rd_word[`CFBS_HIT_MSB:`CFBS_HIT_LSB] = hit_q[bsel_q];
            `CFBS_SEL_TXMASK:
                rd_word[`CFBS_NUM_BUF-1:0] = txmask_q;
            `CFBS_SEL_STATUS:
                rd_word[2:0] = {rxq_valid, ~stg_ready, stg_valid};
            default:
                rd_word = 32'h00000000;
        endcase
    end

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `CFBS_RESP_OKAY;
        end
        else
        begin
            if (s_axi_arvalid & s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_word;
                s_axi_rresp   <= (rd_sel == `CFBS_SEL_NONE) ? `CFBS_RESP_SLVERR
                                                            : `CFBS_RESP_OKAY;
            end
            else if (s_axi_rvalid & s_axi_rready)
            begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule // cfbs_top

`default_nettype wire

// File: verif/cfbs_asserts.sv
`timescale 1ns/100ps
`default_nettype none

module cfbs_asserts (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rstn,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    // Receive queue
    input wire logic        rxq_valid,
    input wire logic        rxq_ready,
    input wire logic [4:0]  rxq_hit,
    input wire logic [15:0] rxq_bytes
);
    logic [7:0] rd_addr_q;

    // Address of the read in flight
    always_ff @(posedge clk or negedge rstn)
        if (!rstn)
            rd_addr_q <= 8'h00;
        else if (s_axi_arvalid && s_axi_arready)
            rd_addr_q <= s_axi_araddr;

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
    chk_bvalid_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    chk_read_unmapped: assert property (s_axi_rvalid && rd_addr_q > 8'h17
        |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read");
    chk_ptr_upper: assert property (s_axi_rvalid && rd_addr_q == 8'h00
        |-> s_axi_rdata[31:16] == 16'h0) else $error("pointer upper half set");
    chk_word7_zero: assert property (s_axi_rvalid && rd_addr_q == 8'h0C
        |-> s_axi_rdata[31:13] == 19'h0 && s_axi_rdata[7:0] == 8'h00)
        else $error("word seven reserved bits set");
    chk_rxq_hold: assert property (rxq_valid && !rxq_ready |=> rxq_valid
        && $stable(rxq_hit) && $stable(rxq_bytes)) else $error("queue output moved");
    chk_hit_range: assert property (rxq_valid |-> rxq_hit[4] == 1'b0)
        else $error("hit code out of range");
endmodule // cfbs_asserts

bind cfbs_top cfbs_asserts u_chk (
    .clk(clk), .rstn(rstn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .rxq_valid(rxq_valid), .rxq_ready(rxq_ready),
    .rxq_hit(rxq_hit), .rxq_bytes(rxq_bytes));

`default_nettype wire

// File: verif/cfbs_rxq_sink.sv
`timescale 1ns/100ps
`default_nettype none

module cfbs_rxq_sink (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Stall control
    input  wire logic        stall,
    // Receive queue
    input  wire logic        rxq_valid,
    output logic             rxq_ready,
    input  wire logic [4:0]  rxq_hit,
    input  wire logic [15:0] rxq_bytes,
    // Captured traffic
    output logic [7:0]       got_n,
    output logic [4:0]       last_hit,
    output logic [15:0]      last_bytes
);
    assign rxq_ready = !stall;

    always_ff @(posedge clk or negedge rstn)
        if (!rstn)
        begin
            got_n      <= 8'h00;
            last_hit   <= 5'h00;
            last_bytes <= 16'h0000;
        end
        else if (rxq_valid && rxq_ready)
        begin
            got_n      <= got_n + 8'h01;
            last_hit   <= rxq_hit;
            last_bytes <= rxq_bytes;
        end
endmodule // cfbs_rxq_sink

`default_nettype wire

// File: verif/cfbs_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "cfbs_consts.vh"

module cfbs_top_tb_top;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        arvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        bready = 1'b1;
    logic        rready = 1'b1;
    logic        fvalid = 1'b0;
    logic [3:0]  ffilt = 4'h0;
    logic [7:0]  fb6 = 8'h00;
    logic [7:0]  fb7 = 8'h00;
    logic        stall = 1'b0;
    wire         awready, wready, bvalid, arready, rvalid, fready, rxq_valid, rxq_ready;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [4:0]  rxq_hit, last_hit;
    wire  [15:0] rxq_bytes, last_bytes;
    wire  [7:0]  got_n;
    logic [31:0] rd;
    logic [1:0]  rs;
    logic [7:0]  exp_n = 8'h00;
    int          fail_count = 0;
    int          samples_checked = 0;

    always #20 clk = ~clk;

    cfbs_top uut (
        .clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .frame_valid(fvalid), .frame_ready(fready), .frame_filter(ffilt),
        .frame_byte6(fb6), .frame_byte7(fb7), .rxq_valid(rxq_valid),
        .rxq_ready(rxq_ready), .rxq_hit(rxq_hit), .rxq_bytes(rxq_bytes));

    cfbs_rxq_sink u_sink (
        .clk(clk), .rstn(rstn), .stall(stall), .rxq_valid(rxq_valid),
        .rxq_ready(rxq_ready), .rxq_hit(rxq_hit), .rxq_bytes(rxq_bytes),
        .got_n(got_n), .last_hit(last_hit), .last_bytes(last_bytes));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [15:0] d);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        awaddr <= a;
        wdata <= {16'h0, d};
        wstrb <= 4'h3;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        // Each channel is released at the edge that takes it
        while (!(aw_done && w_done))
        begin
            @(posedge clk);
            if (!aw_done && awready)
            begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready)
            begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (!bvalid);
        rs = bresp;
    endtask

    task automatic axi_rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        rd = rdata;
        rs = rresp;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        axi_wr(a, d);
        check(rs, `CFBS_RESP_OKAY);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        axi_rd(a);
        check(rd, exp);
    endtask

    task automatic send_frame(input logic [3:0] f, input logic [7:0] b6, input logic [7:0] b7);
        ffilt <= f;
        fb6 <= b6;
        fb7 <= b7;
        fvalid <= 1'b1;
        do @(posedge clk); while (!fready);
        fvalid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs;
        rd_chk(`CFBS_OFF_PTR, 32'h0);
        rd_chk(`CFBS_OFF_TXMASK, 32'h0);
    endtask

    task automatic t_steer(input logic [15:0] ptr);
        logic [7:0] f;
        logic [3:0] d;
        wr(`CFBS_OFF_PTR, ptr);
        for (f = 8'h08; f < 8'h0C; f++)
        begin
            d = ptr[(f - 8) * 4 +: 4];
            send_frame(f[3:0], 8'h60 + f, 8'h70 + f);
            if (d == `CFBS_DEST_FIFO)
            begin
                exp_n++;
                check({3'h0, got_n, last_hit, last_bytes},
                      {3'h0, exp_n, 1'b0, f[3:0], 8'h70 + f, 8'h60 + f});
            end
            else
            begin
                wr(`CFBS_OFF_SEL, {12'h0, d});
                rd_chk(`CFBS_OFF_WORD6, {16'h0, 8'h70 + f, 8'h60 + f});
                rd_chk(`CFBS_OFF_WORD7, {19'h0, f[4:0], 8'h00});
            end
        end
    endtask

    task automatic t_sw;
        wr(`CFBS_OFF_SEL, 16'h0002);
        wr(`CFBS_OFF_WORD6, 16'hA55A);
        rd_chk(`CFBS_OFF_WORD6, 32'h0000A55A);
        wr(`CFBS_OFF_WORD7, 16'hFFFF);
        rd_chk(`CFBS_OFF_WORD7, 32'h00001F00);
    endtask

    task automatic t_tx;
        wr(`CFBS_OFF_TXMASK, 16'h0010);
        wr(`CFBS_OFF_SEL, 16'h0004);
        wr(`CFBS_OFF_WORD7, 16'h1500);
        wr(`CFBS_OFF_PTR, 16'h0040);
        send_frame(4'h9, 8'h11, 8'h22);
        rd_chk(`CFBS_OFF_WORD6, 32'h00002211);
        rd_chk(`CFBS_OFF_WORD7, 32'h00001500);
    endtask

    task automatic t_bad;
        axi_wr(8'h40, 16'h1234);
        check(rs, `CFBS_RESP_SLVERR);
        axi_rd(8'h40);
        check({rs, rd[29:0]}, {`CFBS_RESP_SLVERR, 30'h0});
    endtask

    task automatic t_fill;
        logic [7:0] sent;
        wr(`CFBS_OFF_PTR, 16'hF000);
        stall <= 1'b1;
        sent = 8'h00;
        ffilt <= 4'hB;
        fb6 <= 8'h5A;
        fb7 <= 8'hA5;
        fvalid <= 1'b1;
        repeat (20)
        begin
            @(posedge clk);
            if (fready)
                sent++;
        end
        fvalid <= 1'b0;
        check(fready, 32'h0);
        rd_chk(`CFBS_OFF_STATUS, 32'h00000007);
        // Staged frames must keep the queue destination
        wr(`CFBS_OFF_PTR, 16'h7000);
        stall <= 1'b0;
        repeat (40) @(posedge clk);
        exp_n = exp_n + sent;
        check(got_n, exp_n);
        send_frame(4'hB, 8'h01, 8'h02);
        wr(`CFBS_OFF_SEL, 16'h0007);
        rd_chk(`CFBS_OFF_WORD6, 32'h00000201);
        check(got_n, exp_n);
        rd_chk(`CFBS_OFF_STATUS, 32'h00000000);
    endtask

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial
    begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_regs;
        t_steer(16'hFA50);
        t_steer(16'hE3F1);
        t_sw;
        t_tx;
        t_bad;
        t_fill;
        stop_test;
    end

    initial
    begin
        #(40 * 20000);
        fail_count++;
        stop_test;
    end
endmodule // cfbs_top_tb_top

`default_nettype wire
